// file: csfl_defines.svh
// Constants for the CPU status flag logic: register offset, field
// positions, reset value and bus response codes.
// Assumes inclusion by its bare name from the design and its checker.
`ifndef CSFL_DEFINES_SVH
`define CSFL_DEFINES_SVH

// Byte address of the status word on the register bus
`define CSFL_PSW_OFFSET      16'hFF10
// Field positions within the status word
`define CSFL_BIT_N           0
`define CSFL_BIT_C           1
`define CSFL_BIT_V           2
`define CSFL_BIT_Z           3
`define CSFL_BIT_E           4
`define CSFL_BIT_MULDIV_INTERRUPTED_FLAG       5
`define CSFL_BIT_USER        6
`define CSFL_BIT_HOLD        10
`define CSFL_BIT_IEN         11
`define CSFL_CPU_PRIORITY_LEVEL_LSB        12
`define CSFL_CPU_PRIORITY_LEVEL_MSB        15
// Writable bits; bits 9..7 are reserved and read as zero
`define CSFL_PSW_WMASK       16'hFC7F
`define CSFL_PSW_RESET       16'h0000
// Most negative values of each operand size
`define CSFL_MINNEG_WORD     16'h8000
`define CSFL_MINNEG_BYTE     8'h80
// Highest priority level; nothing maskable preempts it
`define CSFL_CPU_PRIORITY_LEVEL_TOP        4'hF
// Bus response codes
`define CSFL_RESP_OKAY       2'h0
`define CSFL_RESP_SLVERR     2'h2

`endif

// file: csfl_pkg.sv
// Types for the CPU status flag logic: the class of operation that the
// execution pipeline reports at write-back.
// Assumes the defines header sits in the same folder.
package csfl_pkg;

	// Operation class, chooses how the condition flags are formed
	typedef enum logic [3:0] {
		CSFL_OP_NONE  = 4'b0000, // Flags untouched
		CSFL_OP_ADD   = 4'b0001, // Addition
		CSFL_OP_ADDC  = 4'b0010, // Addition with carry
		CSFL_OP_SUB   = 4'b0011, // Subtraction
		CSFL_OP_SUBC  = 4'b0100, // Subtraction with carry
		CSFL_OP_CMP   = 4'b0101, // Comparison
		CSFL_OP_NEG   = 4'b0110, // Two's complement
		CSFL_OP_LOGIC = 4'b0111, // Logical operation
		CSFL_OP_MUL   = 4'b1000, // Multiply
		CSFL_OP_DIV   = 4'b1001, // Divide
		CSFL_OP_SHL   = 4'b1010, // Shift or rotate left
		CSFL_OP_SHR   = 4'b1011, // Shift or rotate right
		CSFL_OP_PRIOR = 4'b1100, // Prioritize (normalize)
		CSFL_OP_BIT1  = 4'b1101, // One-operand Boolean bit op
		CSFL_OP_BIT2  = 4'b1110, // Two-operand Boolean bit op
		CSFL_OP_MOVE  = 4'b1111  // Data movement
	} csfl_op_t;

endpackage : csfl_pkg

// file: csfl_status_word.sv
// Processor status word with condition flag generation, interrupt
// status fields and an AXI4-Lite slave port onto the same register.
// Assumes the execution pipeline presents one write-back per cycle at
// most, with its operands and ALU side results valid in that cycle.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "csfl_defines.svh"

module csfl_status_word
	import csfl_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// AXI4-Lite slave
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Execution pipeline write-back
	input  wire logic        wb_valid,
	input  wire csfl_op_t    wb_op,
	input  wire logic        wb_byte,
	input  wire logic [15:0] wb_result,
	input  wire logic [15:0] wb_op_a,
	input  wire logic [15:0] wb_op_b,
	input  wire logic        wb_carry_out,
	input  wire logic        wb_shift_last,
	input  wire logic        wb_shift_sticky,
	input  wire logic        wb_shift_zero,
	input  wire logic        wb_md_no_fit,
	input  wire logic        wb_div_zero,
	input  wire logic        wb_bit_a,
	input  wire logic        wb_bit_b,
	input  wire logic        wb_table_ok,
	input  wire logic        wb_psw_write,
	input  wire logic [15:0] wb_psw_data,
	// Interrupt entry and return sequencing
	input  wire logic        irq_entry,
	input  wire logic [3:0]  irq_entry_level,
	input  wire logic        irq_muldiv_cut,
	input  wire logic        irq_return,
	input  wire logic [15:0] irq_stacked_psw,
	input  wire logic [3:0]  irq_req_level,
	// Status outputs
	output logic [15:0]      processor_status_word,
	output logic             muldiv_resume,
	output logic             irq_level_ok,
	output logic             global_irq_enable,
	output logic [3:0]       cpu_priority_level,
	output logic             bus_hold_arbitration_enable,
	output logic             user_flag
);

	// Status word storage
	logic [15:0] psw_reg;           // Current status word
	logic [15:0] psw_next;          // Value for the next edge

	// Implicit flags formed from the write-back
	logic        flag_n;            // Negative
	logic        flag_c;            // Carry or borrow
	logic        flag_v;            // Overflow or sticky
	logic        flag_z;            // Zero
	logic        flag_e;            // End of table
	logic        res_msb;           // Sign bit of the operand size
	logic        a_msb;             // Sign of first operand
	logic        b_msb;             // Sign of second operand
	logic        res_zero;          // Result is zero in its size
	logic        src_minneg;        // Source is most negative value

	// Write and read channel state of the bus slave
	logic        aw_got_reg;        // Write address held
	logic        w_got_reg;         // Write data held
	logic [15:0] aw_addr_reg;       // Held write address
	logic [15:0] w_data_reg;        // Held write data, low half
	logic [1:0]  w_strb_reg;        // Held byte enables, low half
	logic        bvalid_reg;        // Write response pending
	logic [1:0]  bresp_reg;         // Write response code
	logic        rvalid_reg;        // Read data pending
	logic [31:0] rdata_reg;         // Read data
	logic [1:0]  rresp_reg;         // Read response code

	// Bus decode helpers
	logic        aw_take;           // Address taken this edge
	logic        w_take;            // Data taken this edge
	logic        aw_have;           // Address available now
	logic        w_have;            // Data available now
	logic        bus_write;         // Both halves present: write now
	logic [15:0] bus_addr;          // Effective write address
	logic [15:0] bus_data;          // Effective write data
	logic [1:0]  bus_strb;          // Effective byte enables
	logic        bus_hit;           // Write targets the status word
	logic [15:0] bus_merged;        // Status word after byte merge

	// Sign and zero taken at the operand size
	always_comb begin
		if (wb_byte) begin
			res_msb    = wb_result[7];
			a_msb      = wb_op_a[7];
			b_msb      = wb_op_b[7];
			res_zero   = (wb_result[7:0] == 8'h00);
			src_minneg = (wb_op_b[7:0] == `CSFL_MINNEG_BYTE);
		end else begin
			res_msb    = wb_result[15];
			a_msb      = wb_op_a[15];
			b_msb      = wb_op_b[15];
			res_zero   = (wb_result == 16'h0000);
			src_minneg = (wb_op_b == `CSFL_MINNEG_WORD);
		end
	end

	// Implicit flag generation per operation class
	always_comb begin
		flag_n = res_msb;
		flag_z = res_zero;
		flag_c = 1'b0;
		flag_v = 1'b0;
		// The source operand is presented on the second operand lane
		flag_e = wb_table_ok & src_minneg;
		case (wb_op)
			CSFL_OP_ADD: begin
				flag_c = wb_carry_out;
				flag_v = (a_msb == b_msb) & (res_msb != a_msb);
			end
			CSFL_OP_ADDC: begin
				flag_c = wb_carry_out;
				flag_v = (a_msb == b_msb) & (res_msb != a_msb);
				// Chained zero for multiple-precision sums
				flag_z = psw_reg[`CSFL_BIT_Z] & res_zero;
			end
			CSFL_OP_SUB, CSFL_OP_CMP: begin
				flag_c = ~wb_carry_out;
				flag_v = (a_msb != b_msb) & (res_msb != a_msb);
			end
			CSFL_OP_SUBC: begin
				flag_c = ~wb_carry_out;
				flag_v = (a_msb != b_msb) & (res_msb != a_msb);
				flag_z = psw_reg[`CSFL_BIT_Z] & res_zero;
			end
			CSFL_OP_NEG: begin
				// Only the most negative value cannot be negated
				flag_c = ~wb_carry_out;
				flag_v = res_msb & b_msb;
			end
			CSFL_OP_LOGIC: begin
				flag_c = 1'b0;
				flag_v = 1'b0;
			end
			CSFL_OP_MUL: begin
				flag_c = 1'b0;
				flag_v = wb_md_no_fit;
			end
			CSFL_OP_DIV: begin
				flag_c = 1'b0;
				flag_v = wb_md_no_fit | wb_div_zero;
			end
			CSFL_OP_SHL: begin
				flag_c = ~wb_shift_zero & wb_shift_last;
			end
			CSFL_OP_SHR: begin
				// Carry and sticky together grade the rounding error
				flag_c = ~wb_shift_zero & wb_shift_last;
				flag_v = ~wb_shift_zero & wb_shift_sticky;
			end
			CSFL_OP_PRIOR: begin
				flag_c = 1'b0;
				flag_z = (wb_op_b == 16'h0000);
			end
			CSFL_OP_BIT1: begin
				flag_n = wb_bit_a;
				flag_z = ~wb_bit_a;
			end
			CSFL_OP_BIT2: begin
				flag_n = wb_bit_a ^ wb_bit_b;
				flag_c = wb_bit_a & wb_bit_b;
				flag_v = wb_bit_a | wb_bit_b;
				flag_z = ~(wb_bit_a | wb_bit_b);
			end
			CSFL_OP_MOVE: begin
				flag_c = psw_reg[`CSFL_BIT_C];
				flag_v = psw_reg[`CSFL_BIT_V];
			end
			default: begin
				// No flag change: hold every flag
				flag_n = psw_reg[`CSFL_BIT_N];
				flag_c = psw_reg[`CSFL_BIT_C];
				flag_v = psw_reg[`CSFL_BIT_V];
				flag_z = psw_reg[`CSFL_BIT_Z];
				flag_e = psw_reg[`CSFL_BIT_E];
			end
		endcase
	end

	// Bus write decode; address and data may arrive in either order
	assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
	assign aw_take   = s_axi_awvalid & s_axi_awready;
	assign w_take    = s_axi_wvalid & s_axi_wready;
	assign aw_have   = aw_got_reg | aw_take;
	assign w_have    = w_got_reg | w_take;
	assign bus_write = aw_have & w_have;
	assign bus_addr  = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
	assign bus_data  = w_got_reg ? w_data_reg : s_axi_wdata[15:0];
	assign bus_strb  = w_got_reg ? w_strb_reg : s_axi_wstrb[1:0];
	assign bus_hit   = (bus_addr[15:2] == 14'(`CSFL_PSW_OFFSET >> 2));
	// Byte lanes merge into the current word
	assign bus_merged = {bus_strb[1] ? bus_data[15:8] : psw_reg[15:8],
		bus_strb[0] ? bus_data[7:0] : psw_reg[7:0]};

	// Next status word; later assignments take priority
	always_comb begin
		psw_next = psw_reg;
		// Flags land together with the result write-back
		if (wb_valid) begin
			psw_next[`CSFL_BIT_N] = flag_n;
			psw_next[`CSFL_BIT_C] = flag_c;
			psw_next[`CSFL_BIT_V] = flag_v;
			psw_next[`CSFL_BIT_Z] = flag_z;
			psw_next[`CSFL_BIT_E] = flag_e;
		end
		// Return restores the stacked word, muldiv flag included
		if (irq_return) begin
			psw_next = irq_stacked_psw & `CSFL_PSW_WMASK;
		end
		// Entry raises the level and records a cut-short muldiv
		if (irq_entry) begin
			psw_next[`CSFL_CPU_PRIORITY_LEVEL_MSB:`CSFL_CPU_PRIORITY_LEVEL_LSB] = irq_entry_level;
			psw_next[`CSFL_BIT_MULDIV_INTERRUPTED_FLAG] = irq_muldiv_cut;
		end
		// Software write from the register bus
		if (bus_write && bus_hit) begin
			psw_next = bus_merged & `CSFL_PSW_WMASK;
		end
		// An explicit write by the instruction overrides its own flags
		if (wb_valid && wb_psw_write) begin
			psw_next = wb_psw_data & `CSFL_PSW_WMASK;
		end
	end

	// Status word register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			psw_reg <= `CSFL_PSW_RESET;
		end else begin
			psw_reg <= psw_next;
		end
	end

	// Write channel capture while the other half is missing
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			aw_addr_reg <= 16'h0000;
			w_data_reg  <= 16'h0000;
			w_strb_reg  <= 2'h0;
		end else if (bus_write) begin
			// Both present: consumed this edge
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata[15:0];
				w_strb_reg <= s_axi_wstrb[1:0];
			end
		end
	end

	// Write response, held until the master takes it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `CSFL_RESP_OKAY;
		end else if (bus_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= bus_hit ? `CSFL_RESP_OKAY : `CSFL_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read channel; the word shown is that left by the last edge
	assign s_axi_arready = ~rvalid_reg;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= `CSFL_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			if (s_axi_araddr[15:2] == 14'(`CSFL_PSW_OFFSET >> 2)) begin
				rdata_reg <= {16'h0000, psw_reg};
				rresp_reg <= `CSFL_RESP_OKAY;
			end else begin
				// Unmapped: zero data with an error response
				rdata_reg <= 32'h00000000;
				rresp_reg <= `CSFL_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Bus outputs
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// Status view for the pipeline; instructions read the settled word
	assign processor_status_word = psw_reg;
	assign global_irq_enable     = psw_reg[`CSFL_BIT_IEN];
	assign cpu_priority_level    =
		psw_reg[`CSFL_CPU_PRIORITY_LEVEL_MSB:`CSFL_CPU_PRIORITY_LEVEL_LSB];
	assign bus_hold_arbitration_enable = psw_reg[`CSFL_BIT_HOLD];
	assign user_flag = psw_reg[`CSFL_BIT_USER];

	// Resume decision uses the flag being restored on return
	assign muldiv_resume = irq_return &
		irq_stacked_psw[`CSFL_BIT_MULDIV_INTERRUPTED_FLAG];

	// Maskable request must beat the level; level 15 admits nothing
	assign irq_level_ok = psw_reg[`CSFL_BIT_IEN] &
		(cpu_priority_level != `CSFL_CPU_PRIORITY_LEVEL_TOP) &
		(irq_req_level > cpu_priority_level);

endmodule : csfl_status_word

// file: csfl_status_word_chk.sv
// Checker for the status word block: flag forming, override order and
// interrupt fields. Assumes it is bound onto csfl_status_word.
`timescale 1ns/1ns
`include "csfl_defines.svh"
module csfl_status_word_chk
	import csfl_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        wb_valid,
	input wire csfl_op_t    wb_op,
	input wire logic        wb_byte,
	input wire logic [15:0] wb_result,
	input wire logic [15:0] wb_op_a,
	input wire logic [15:0] wb_op_b,
	input wire logic        wb_carry_out,
	input wire logic        wb_bit_a,
	input wire logic        wb_bit_b,
	input wire logic        wb_psw_write,
	input wire logic [15:0] wb_psw_data,
	input wire logic        irq_entry,
	input wire logic [3:0]  irq_entry_level,
	input wire logic        irq_muldiv_cut,
	input wire logic        irq_return,
	input wire logic [15:0] irq_stacked_psw,
	input wire logic [15:0] processor_status_word,
	input wire logic        muldiv_resume,
	input wire logic        irq_level_ok,
	input wire logic [3:0]  cpu_priority_level
);
	logic quiet;    // Implicit flags only, no other writer this cycle
	logic add_v;    // Signed overflow of a word addition
	logic res_zero; // Whole result is zero

	// Bus writes and interrupt returns outrank implicit flags, so skip them and entries
	assign quiet = wb_valid & ~wb_psw_write & ~irq_entry & ~irq_return
		& ~s_axi_awvalid & ~s_axi_wvalid;
	assign add_v = (wb_op_a[15] == wb_op_b[15])
		& (wb_result[15] != wb_op_a[15]);
	assign res_zero = (wb_result == 16'h0000);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_add_nv;
		quiet && wb_op == CSFL_OP_ADD && !wb_byte |=>
			processor_status_word[0] == $past(wb_result[15]) &&
			processor_status_word[2] == $past(add_v);
	endproperty
	a_add_nv: assert property (p_add_nv)
		else $error("add sign or overflow flag wrong");
	property p_add_c;
		quiet && wb_op == CSFL_OP_ADD |=>
			processor_status_word[1] == $past(wb_carry_out);
	endproperty
	a_add_c: assert property (p_add_c)
		else $error("add carry flag wrong");
	property p_sub_c;
		quiet && (wb_op == CSFL_OP_SUB || wb_op == CSFL_OP_CMP) |=>
			processor_status_word[1] == !$past(wb_carry_out);
	endproperty
	a_sub_c: assert property (p_sub_c)
		else $error("borrow flag wrong");
	property p_clr_c;
		quiet && wb_op inside {CSFL_OP_LOGIC, CSFL_OP_MUL, CSFL_OP_DIV}
			|=> !processor_status_word[1];
	endproperty
	a_clr_c: assert property (p_clr_c)
		else $error("carry left set");
	property p_bit2;
		quiet && wb_op == CSFL_OP_BIT2 |=> processor_status_word[3:0] ==
			{$past(~(wb_bit_a | wb_bit_b)), $past(wb_bit_a | wb_bit_b),
			$past(wb_bit_a & wb_bit_b), $past(wb_bit_a ^ wb_bit_b)};
	endproperty
	a_bit2: assert property (p_bit2)
		else $error("two-bit flags wrong");
	property p_addc_z;
		quiet && !wb_byte && wb_op inside {CSFL_OP_ADDC, CSFL_OP_SUBC} |=>
			processor_status_word[3] ==
			($past(processor_status_word[3]) && $past(res_zero));
	endproperty
	a_addc_z: assert property (p_addc_z)
		else $error("chained zero flag wrong");
	property p_explicit;
		wb_valid && wb_psw_write |=> processor_status_word ==
			($past(wb_psw_data) & `CSFL_PSW_WMASK);
	endproperty
	a_explicit: assert property (p_explicit)
		else $error("explicit write lost");
	property p_entry;
		irq_entry && !wb_psw_write && !s_axi_awvalid && !s_axi_wvalid |=>
			cpu_priority_level == $past(irq_entry_level) &&
			processor_status_word[5] == $past(irq_muldiv_cut);
	endproperty
	a_entry: assert property (p_entry)
		else $error("entry did not load level and flag");
	property p_top;
		cpu_priority_level == `CSFL_CPU_PRIORITY_LEVEL_TOP |-> !irq_level_ok;
	endproperty
	a_top: assert property (p_top)
		else $error("top level let a request through");
	property p_resume;
		irq_return |-> muldiv_resume == irq_stacked_psw[5];
	endproperty
	a_resume: assert property (p_resume)
		else $error("resume does not follow stacked flag");

	c_bit2: cover property (wb_valid && wb_op == CSFL_OP_BIT2);
	c_entry: cover property (irq_entry);
	c_explicit: cover property (wb_valid && wb_psw_write);
endmodule : csfl_status_word_chk

bind csfl_status_word csfl_status_word_chk chk (.*);

// file: csfl_cpu_model.sv
// Behavioural execution pipeline and interrupt sequencer feeding the
// status word block. Assumes the bench calls its tasks in turn.
`timescale 1ns/1ns
module csfl_cpu_model
	import csfl_pkg::*;
(
	input  wire logic  mclk,
	output logic       wb_valid,
	output csfl_op_t   wb_op,
	output logic       wb_byte,
	output logic [15:0] wb_result,
	output logic [15:0] wb_op_a,
	output logic [15:0] wb_op_b,
	output logic       wb_carry_out,
	output logic       wb_shift_last,
	output logic       wb_shift_sticky,
	output logic       wb_shift_zero,
	output logic       wb_md_no_fit,
	output logic       wb_div_zero,
	output logic       wb_bit_a,
	output logic       wb_bit_b,
	output logic       wb_table_ok,
	output logic       wb_psw_write,
	output logic [15:0] wb_psw_data,
	output logic       irq_entry,
	output logic [3:0] irq_entry_level,
	output logic       irq_muldiv_cut,
	output logic       irq_return,
	output logic [15:0] irq_stacked_psw
);
	// Idle pipeline at time zero
	initial begin
		wb_op = CSFL_OP_NONE;
		{wb_valid, wb_byte, wb_result, wb_op_a, wb_op_b, wb_psw_write} = '0;
		{wb_carry_out, wb_shift_last, wb_shift_sticky, wb_shift_zero} = '0;
		{wb_md_no_fit, wb_div_zero, wb_bit_a, wb_bit_b, wb_table_ok} = '0;
		{wb_psw_data, irq_entry, irq_entry_level, irq_muldiv_cut} = '0;
		{irq_return, irq_stacked_psw} = '0;
	end

	// One write-back pulse; operands scrambled after, so stale data shows
	task automatic exec(input csfl_op_t op, input logic [9:0] f,
		input logic [15:0] r, a, b, input logic pw, input logic [15:0] pd);
		@(posedge mclk);
		wb_valid <= 1'b1;
		wb_op <= op;
		{wb_byte, wb_table_ok, wb_bit_b, wb_bit_a, wb_div_zero, wb_md_no_fit,
			wb_shift_zero, wb_shift_sticky, wb_shift_last, wb_carry_out} <= f;
		{wb_result, wb_op_a, wb_op_b} <= {r, a, b};
		{wb_psw_write, wb_psw_data} <= {pw, pd};
		@(posedge mclk);
		wb_valid <= 1'b0;
		wb_psw_write <= 1'b0;
		wb_op <= CSFL_OP_NONE;
		{wb_result, wb_op_a, wb_op_b} <= ~{r, a, b};
	endtask : exec

	// One interrupt entry and/or return pulse
	task automatic irq(input logic e, input logic [3:0] l, input logic c,
		input logic rt, input logic [15:0] s);
		@(posedge mclk);
		{irq_entry, irq_entry_level, irq_muldiv_cut} <= {e, l, c};
		{irq_return, irq_stacked_psw} <= {rt, s};
		@(posedge mclk);
		{irq_entry, irq_return} <= 2'h0;
		irq_stacked_psw <= ~s;
	endtask : irq
endmodule : csfl_cpu_model

// file: csfl_status_word_test.sv
// Self-checking bench for the status word block over its register bus,
// pipeline and interrupt ports. Assumes the pipeline model alongside.
`timescale 1ns/1ns
module csfl_status_word_test
	import csfl_pkg::*;
;
	logic        mclk, reset_n, irq_entry, irq_muldiv_cut, irq_return;
	logic [15:0] s_axi_awaddr, s_axi_araddr, irq_stacked_psw;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, irq_req_level, irq_entry_level;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, wb_valid, wb_byte, wb_bit_a;
	csfl_op_t    wb_op;
	logic        wb_carry_out, wb_shift_last, wb_shift_sticky, wb_bit_b;
	logic        wb_shift_zero, wb_md_no_fit, wb_div_zero, wb_table_ok;
	logic [15:0] wb_result, wb_op_a, wb_op_b, wb_psw_data;
	logic [15:0] processor_status_word;
	logic        wb_psw_write, muldiv_resume, irq_level_ok, user_flag;
	logic        global_irq_enable, bus_hold_arbitration_enable;
	logic [3:0]  cpu_priority_level;
	int          n_mismatch, samples_checked, i;
	// Case: op, {byte,table,bit_b,bit_a,div0,nofit,cnt0,sticky,last,carry},
	// result, op_a, op_b, expected {E,Z,V,C,N}
	logic [66:0] tab [21] = '{
		{CSFL_OP_ADD, 10'h100, 48'h8000_7FFF_0001, 5'h05},
		{CSFL_OP_ADD, 10'h101, 48'h0000_FFFF_0001, 5'h0A},
		{CSFL_OP_ADD, 10'h300, 48'h0080_007F_0001, 5'h05},
		{CSFL_OP_SUB, 10'h100, 48'hFFFF_0000_0001, 5'h03},
		{CSFL_OP_CMP, 10'h101, 48'h0000_0005_0005, 5'h08},
		{CSFL_OP_ADDC, 10'h100, 48'h0, 5'h08},
		{CSFL_OP_NEG, 10'h100, 48'h8000_0000_8000, 5'h17},
		{CSFL_OP_SUBC, 10'h101, 48'h0, 5'h00},
		{CSFL_OP_LOGIC, 10'h101, 48'h0, 5'h08},
		{CSFL_OP_MUL, 10'h111, 48'h0001_0000_0002, 5'h04},
		{CSFL_OP_DIV, 10'h120, 48'h8000_0000_0000, 5'h05},
		{CSFL_OP_SHR, 10'h103, 48'h0001_0000_0001, 5'h02},
		{CSFL_OP_SHR, 10'h104, 48'h0000_0000_0001, 5'h0C},
		{CSFL_OP_SHR, 10'h10F, 48'h0004_0000_0001, 5'h00},
		{CSFL_OP_PRIOR, 10'h101, 48'h0000_0000_0005, 5'h00},
		{CSFL_OP_BIT1, 10'h040, 48'h0, 5'h01},
		{CSFL_OP_BIT2, 10'h040, 48'h0, 5'h05},
		{CSFL_OP_BIT2, 10'h0C0, 48'h0, 5'h06},
		{CSFL_OP_BIT2, 10'h000, 48'h0, 5'h08},
		{CSFL_OP_MOVE, 10'h300, 48'h0080_0000_0080, 5'h11},
		{CSFL_OP_NONE, 10'h000, 48'h0, 5'h11}};

	csfl_status_word uut (.*);
	csfl_cpu_model cpu (.*);

	// Free-running 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Counts every comparison, reports and counts each mismatch
	task automatic chk(input logic [15:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// Bus write: address and data offered together, response awaited
	task automatic axw(input logic [15:0] a, d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge mclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 16'h0000, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				chk({14'h0000, s_axi_bresp}, {14'h0000, er});
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : axw

	// Bus read with expected data and response
	task automatic axr(input logic [15:0] a, ed, input logic [1:0] er);
		@(posedge mclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				chk(s_axi_rdata[15:0], ed);
				chk({14'h0000, s_axi_rresp}, {14'h0000, er});
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : axr

	// Single end of run for the tests and the watchdog
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	// Watchdog far beyond the hundred or so cycles the tests need
	initial begin
		#(4000 * 40);
		n_mismatch++;
		summarize();
	end

	// Main sequence
	initial begin
		reset_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, irq_req_level} = '0;
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		#1 chk(processor_status_word, 16'h0000);
		chk({15'h0000, irq_level_ok}, 16'h0000);
		axr(16'hFF10, 16'h0000, 2'h0);
		axw(16'hFF10, 16'hFFFF, 4'h3, 2'h0);
		axr(16'hFF10, 16'hFC7F, 2'h0);
		chk({12'h000, global_irq_enable, bus_hold_arbitration_enable,
			user_flag, 1'b0}, 16'h000E);
		@(posedge mclk);
		irq_req_level <= 4'hF;
		#1 chk({15'h0000, irq_level_ok}, 16'h0000);
		// Low lane only, then an unmapped place that must change nothing
		axw(16'hFF10, 16'h0000, 4'h1, 2'h0);
		axw(16'hFF14, 16'h0000, 4'h3, 2'h2);
		axr(16'hFF14, 16'h0000, 2'h2);
		axr(16'hFF10, 16'hFC00, 2'h0);
		axw(16'hFF10, 16'h3800, 4'h3, 2'h0);
		@(posedge mclk);
		irq_req_level <= 4'h4;
		#1 chk({15'h0000, irq_level_ok}, 16'h0001);
		@(posedge mclk);
		irq_req_level <= 4'h3;
		#1 chk({15'h0000, irq_level_ok}, 16'h0000);
		// Flag table; the prioritize case leaves overflow open
		for (i = 0; i < 21; i++) begin
			cpu.exec(csfl_op_t'(tab[i][66:63]), tab[i][62:53],
				tab[i][52:37], tab[i][36:21], tab[i][20:5], 1'b0, 16'h0000);
			#1 chk({11'h000, processor_status_word[4:0] &
				((i == 14) ? 5'h1B : 5'h1F)}, {11'h000, tab[i][4:0]});
		end
		cpu.exec(CSFL_OP_ADD, 10'h101, 16'h0, 16'h0, 16'h0, 1'b1, 16'h1041);
		#1 chk(processor_status_word, 16'h1041);
		axr(16'hFF10, 16'h1041, 2'h0);
		cpu.irq(1'b1, 4'h9, 1'b1, 1'b0, 16'h0000);
		#1 chk(processor_status_word, 16'h9061);
		chk({12'h000, cpu_priority_level}, 16'h0009);
		// Resume request is looked at while the return pulse stands
		fork
			cpu.irq(1'b0, 4'h0, 1'b0, 1'b1, 16'h2820);
			begin
				@(posedge mclk);
				#1 chk({15'h0000, muldiv_resume}, 16'h0001);
			end
		join
		#1 chk(processor_status_word, 16'h2820);
		chk({15'h0000, muldiv_resume}, 16'h0000);
		summarize();
	end
endmodule : csfl_status_word_test
